/* File: common/hcpwm_pkg.sv */
// Operation
// R1: Period lasts period value plus one counts
// R2: Software keeps duty between 1 and period-1
// R3: Duty falling edge moved by phase steps
// R4: Lost lock sets sticky flag, software clears
// R5: Lost lock triggers automatic relock, flag kept
// R6: Protection off keeps flag zero, no relock
// R7: Loop off: plain PWM, no dead time
// R8: Loop on forces clock select to 00
// R9: Counter clock is oscillator divided 1/2/4/8
// R10: Function bit clear holds counter at zero
// R11: Dead time is 2k to 2k+1 steps
// R12: Dead-time taps derived from dead-time code
// R13: Active control zero forces outputs inactive
// R14: Buck steers duty high, boost steers low
// R15: Each output inverted by its own bit
// R16: Four enables route OCP/OVP to outputs
// R17: Duty and period from their registers
// R18: Phase write buffered, moved on duty write
// R19: Duty read copies phase into buffer
// R20: Dead time at every rise with loop on, no overlap
// R21: Output high from period start until duty
package hcpwm_pkg;

  // ****************************************
  // Register map (word index, byte = 4*idx)
  // ****************************************
  localparam logic [2:0] IDX_PERIOD = 3'h0;
  localparam logic [2:0] IDX_DUTY = 3'h1;
  localparam logic [2:0] IDX_PHASE = 3'h2;
  localparam logic [2:0] IDX_CLKDT = 3'h3;
  localparam logic [2:0] IDX_OUTCTL = 3'h4;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [7:0] PERIOD_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [3:0] PHASE_RST = 4'h0;
  localparam logic [7:0] CLKDT_RST = 8'h80;
  localparam logic [7:0] OUTCTL_RST = 8'h20;
  localparam int unsigned PHASE_LSB = 4;
  localparam int unsigned LOCK_FLAG_BIT = 0;

  // ****************************************
  // Timing: clk_i is the delay-loop step clock
  // ****************************************
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned STEP_PS = 25000;
  localparam int unsigned STEP_CYCLES = (STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned STEPS_PER_OSC = 16 * STEP_CYCLES;

  typedef struct packed {
    logic lock_protect_enable;
    logic delay_loop_enable;
    logic [1:0] counter_clock_select;
    logic pwm_function_enable;
    logic [2:0] dead_time_code;
  } hcpwm_clkdt_t;

  typedef struct packed {
    logic output_active_control;
    logic converter_type_select;
    logic high_output_invert;
    logic low_output_invert;
    logic overcurrent_high_enable;
    logic overcurrent_low_enable;
    logic overvoltage_high_enable;
    logic overvoltage_low_enable;
  } hcpwm_outctl_t;

  // Code k maps to 2k+1 steps, inside the 2k..2k+1 window
  function automatic logic [3:0] dead_taps(input logic [2:0] code);
    dead_taps = {code, 1'b1};
  endfunction

endpackage

/* File: logic/hcpwm_dead_delay.sv */
`timescale 1ns/100ps
// ****************************************
// Rising-edge delay for one output leg
// ****************************************
module hcpwm_dead_delay (
  input logic clk_i,        // Step clock
  input logic rst_i,        // Sync reset, high
  input logic enable_i,     // Dead time active
  input logic level_i,      // Undelayed drive
  input logic [3:0] delay_i, // Steps of delay
  output logic level_o      // Delayed drive
);

  logic lvl_dly_reg;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic out_reg;
  logic out_next;
  wire rise = level_i & ~lvl_dly_reg;

  // Load delay-1 on each rise so the leg lags by exactly delay steps; falls pass at once
  assign cnt_next = !level_i ? 4'h0 :
                    rise ? ((delay_i == 4'h0) ? 4'h0 : delay_i - 4'h1) :
                    (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0; // [R20]
  assign out_next = enable_i ? (level_i & (rise ? (delay_i == 4'h0) : (cnt_reg == 4'h0))) : level_i; // [R7] [R11]

  // Same one-cycle latency in both modes keeps the legs aligned
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_dly_reg <= 1'b0;
      cnt_reg <= 4'h0;
      out_reg <= 1'b0;
    end else begin
      lvl_dly_reg <= level_i;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign level_o = out_reg;

endmodule // hcpwm_dead_delay

/* File: logic/hcpwm_top.sv */
`timescale 1ns/100ps
// ****************************************
// High-resolution complementary PWM
// ****************************************
module hcpwm_top (
  input logic clk_i,                       // 40 MHz step clock
  input logic rst_i,                       // Sync reset, high
  input logic wb_cyc_i,                    // Wishbone cycle
  input logic wb_stb_i,                    // Wishbone strobe
  input logic wb_we_i,                     // Write enable
  input logic [7:0] wb_adr_i,              // Byte address
  input logic [3:0] wb_sel_i,              // Byte selects
  input logic [31:0] wb_dat_i,             // Write data
  input logic lock_lost_i,                 // Delay loop lost lock
  input logic ocp_trip_i,                  // Over-current event
  input logic ovp_trip_i,                  // Over-voltage event
  output logic wb_ack_o,                   // Wishbone ack
  output logic [31:0] wb_dat_o,            // Read data
  output logic high_side_output_o,         // High-side drive
  output logic low_side_output_o,          // Low-side drive
  output logic dll_enable_o,               // Delay loop on
  output logic dll_relock_o,               // Relock request
  output logic [3:0] high_dead_tap_select_o, // High leg tap
  output logic [3:0] low_dead_tap_select_o   // Low leg tap
);

  // ****************************************
  // Bus decode
  // ****************************************
  function automatic logic hit(input logic [7:0] adr, input logic [2:0] idx);
    hit = (adr[7:5] == 3'h0) && (adr[1:0] == 2'h0) && (adr[4:2] == idx);
  endfunction

  logic wb_ack_reg;
  logic [31:0] wb_dat_reg;
  logic [7:0] period_reg;
  logic [7:0] duty_reg;
  logic [3:0] phase_reg;
  logic [3:0] phase_buf_reg;
  logic lock_flag_reg;
  hcpwm_pkg::hcpwm_clkdt_t clkdt_reg;
  hcpwm_pkg::hcpwm_outctl_t outctl_reg;

  // Request taken once; ack blocks a second take in the ack cycle
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
  wire wr_lo = wb_req & wb_we_i & wb_sel_i[0];
  wire rd = wb_req & ~wb_we_i;
  wire wr_period = wr_lo & hit(wb_adr_i, hcpwm_pkg::IDX_PERIOD);
  wire wr_duty = wr_lo & hit(wb_adr_i, hcpwm_pkg::IDX_DUTY);
  wire wr_phase = wr_lo & hit(wb_adr_i, hcpwm_pkg::IDX_PHASE);
  wire wr_clkdt = wr_lo & hit(wb_adr_i, hcpwm_pkg::IDX_CLKDT);
  wire wr_outctl = wr_lo & hit(wb_adr_i, hcpwm_pkg::IDX_OUTCTL);
  wire rd_duty = rd & hit(wb_adr_i, hcpwm_pkg::IDX_DUTY);

  // Read mux; unmapped words read zero but still ack
  wire [7:0] phase_view = {phase_buf_reg, 3'h0, lock_flag_reg};
  wire [7:0] rd_byte = hit(wb_adr_i, hcpwm_pkg::IDX_PERIOD) ? period_reg :
                       hit(wb_adr_i, hcpwm_pkg::IDX_DUTY) ? duty_reg :
                       hit(wb_adr_i, hcpwm_pkg::IDX_PHASE) ? phase_view : // [R19]
                       hit(wb_adr_i, hcpwm_pkg::IDX_CLKDT) ? clkdt_reg :
                       hit(wb_adr_i, hcpwm_pkg::IDX_OUTCTL) ? outctl_reg : 8'h00;
  wire [31:0] wb_dat_next = wb_req ? {24'h0, rd_byte} : wb_dat_reg;

  // ****************************************
  // Register next values
  // ****************************************
  wire [7:0] clkdt_wr = wr_clkdt ? wb_dat_i[7:0] : clkdt_reg;
  // Loop on pins the clock select at 00 and drops writes to it
  wire [1:0] cksel_next = clkdt_wr[6] ? 2'b00 : clkdt_wr[5:4]; // [R8] [R7]
  wire [7:0] clkdt_next = {clkdt_wr[7:6], cksel_next, clkdt_wr[3:0]};
  wire [3:0] phase_next = wr_duty ? phase_buf_reg : phase_reg; // [R18]
  wire [3:0] phase_buf_next = wr_phase ? wb_dat_i[7:4] : rd_duty ? phase_reg : phase_buf_reg; // [R18] [R19]

  // Lock flag: hardware set beats a software clear in the same cycle
  wire lock_set = clkdt_reg.lock_protect_enable & clkdt_reg.delay_loop_enable & lock_lost_i; // [R4]
  wire lock_clr = wr_phase & ~wb_dat_i[hcpwm_pkg::LOCK_FLAG_BIT]; // [R4]
  wire lock_flag_next = clkdt_reg.lock_protect_enable & (lock_set | (lock_flag_reg & ~lock_clr)); // [R6]

  // Bus and register state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0;
      period_reg <= hcpwm_pkg::PERIOD_RST;
      duty_reg <= hcpwm_pkg::DUTY_RST;
      phase_reg <= hcpwm_pkg::PHASE_RST;
      phase_buf_reg <= hcpwm_pkg::PHASE_RST;
      lock_flag_reg <= 1'b0;
      clkdt_reg <= hcpwm_pkg::CLKDT_RST;
      outctl_reg <= hcpwm_pkg::OUTCTL_RST;
    end else begin
      wb_ack_reg <= wb_req;
      wb_dat_reg <= wb_dat_next;
      period_reg <= wr_period ? wb_dat_i[7:0] : period_reg; // [R17]
      duty_reg <= wr_duty ? wb_dat_i[7:0] : duty_reg; // [R17]
      phase_reg <= phase_next;
      phase_buf_reg <= phase_buf_next;
      lock_flag_reg <= lock_flag_next;
      clkdt_reg <= clkdt_next;
      outctl_reg <= wr_outctl ? wb_dat_i[7:0] : outctl_reg;
    end
  end

  // ****************************************
  // Counter clock and period counter
  // ****************************************
  // Oscillator period is 16 steps; divide by 1, 2, 4 or 8 on top
  function automatic logic [6:0] div_limit(input logic [1:0] sel);
    div_limit = 7'((hcpwm_pkg::STEPS_PER_OSC << sel) - 1);
  endfunction

  logic [6:0] pre_reg;
  logic [7:0] cnt_reg;
  wire pwm_on = clkdt_reg.pwm_function_enable;
  wire dll_on = clkdt_reg.delay_loop_enable;
  wire tick = (pre_reg == div_limit(clkdt_reg.counter_clock_select)); // [R9]
  wire [6:0] pre_next = (!pwm_on || tick) ? 7'h0 : pre_reg + 7'h1;
  // Wrap after the period-th count; >= also recovers if period shrinks
  wire [7:0] cnt_wrap = (cnt_reg >= period_reg) ? 8'h00 : cnt_reg + 8'h01; // [R1]
  wire [7:0] cnt_next = !pwm_on ? 8'h00 : tick ? cnt_wrap : cnt_reg; // [R10]

  // ****************************************
  // Duty pulse with fine falling edge
  // ****************************************
  logic raw_dly_reg;
  logic [3:0] fine_reg;
  logic hr_reg;
  wire raw = pwm_on & (cnt_reg < duty_reg); // [R21] [R17]
  wire fall = raw_dly_reg & ~raw;
  // Falling edge stretched by phase steps, phase 0 adds nothing
  wire fine_hold = dll_on & (fall ? (phase_reg != 4'h0) : (fine_reg != 4'h0)); // [R3]
  wire [3:0] fine_next = !dll_on ? 4'h0 : (fall && phase_reg != 4'h0) ? phase_reg - 4'h1 :
                         (fine_reg != 4'h0) ? fine_reg - 4'h1 : 4'h0; // [R3]
  wire hr_next = raw | fine_hold; // [R7]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_reg <= 7'h0;
      cnt_reg <= 8'h00;
      raw_dly_reg <= 1'b0;
      fine_reg <= 4'h0;
      hr_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      raw_dly_reg <= raw;
      fine_reg <= fine_next;
      hr_reg <= hr_next;
    end
  end

  // ****************************************
  // Steering, dead time, protection, inversion
  // ****************************************
  logic [3:0] taps_reg;
  logic [1:0] leg_in;
  logic [1:0] leg_out;
  // Buck puts the duty on the high leg, boost on the low leg
  assign leg_in[0] = outctl_reg.converter_type_select ? ~hr_reg : hr_reg; // [R14]
  assign leg_in[1] = outctl_reg.converter_type_select ? hr_reg : ~hr_reg; // [R14]

  genvar g;
  for (g = 0; g < 2; g++) begin : g_leg
    hcpwm_dead_delay u_dead (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .enable_i(dll_on),
      .level_i(leg_in[g]),
      .delay_i(taps_reg),
      .level_o(leg_out[g])
    ); // [R20]
  end

  // Each leg only sees the protections routed to it
  wire prot_h = (outctl_reg.overcurrent_high_enable & ocp_trip_i) |
                (outctl_reg.overvoltage_high_enable & ovp_trip_i); // [R16]
  wire prot_l = (outctl_reg.overcurrent_low_enable & ocp_trip_i) |
                (outctl_reg.overvoltage_low_enable & ovp_trip_i); // [R16]
  wire act = outctl_reg.output_active_control;
  wire drive_h = leg_out[0] & act & ~prot_h; // [R13]
  wire drive_l = leg_out[1] & act & ~prot_l; // [R13]
  wire high_next = drive_h ^ outctl_reg.high_output_invert; // [R15]
  wire low_next = drive_l ^ outctl_reg.low_output_invert; // [R15]

  logic high_reg;
  logic low_reg;
  logic dll_en_reg;
  logic relock_reg;

  // Output flops; relock pulses each cycle lock is reported lost while protection and loop are on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      taps_reg <= hcpwm_pkg::dead_taps(3'h0);
      high_reg <= 1'b0;
      low_reg <= 1'b0;
      dll_en_reg <= 1'b0;
      relock_reg <= 1'b0;
    end else begin
      taps_reg <= hcpwm_pkg::dead_taps(clkdt_reg.dead_time_code); // [R12] [R11]
      high_reg <= high_next;
      low_reg <= low_next;
      dll_en_reg <= dll_on;
      relock_reg <= lock_set; // [R5]
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;
  assign high_side_output_o = high_reg;
  assign low_side_output_o = low_reg;
  assign dll_enable_o = dll_en_reg;
  assign dll_relock_o = relock_reg;
  assign high_dead_tap_select_o = taps_reg;
  assign low_dead_tap_select_o = taps_reg;

  // ****************************************
  // Assertions
  // ****************************************
  AST_PERIOD_WRAP: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    pwm_on && tick && cnt_reg == period_reg |=> cnt_reg == 8'h00)
    else $error("counter did not wrap after period value");

  AST_COUNTER_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    !pwm_on |=> cnt_reg == 8'h00 && pre_reg == 7'h0)
    else $error("counter not held at zero while disabled");

  AST_FLAG_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    !clkdt_reg.lock_protect_enable |=> !lock_flag_reg && !relock_reg)
    else $error("lock flag or relock active without protection");

  AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    clkdt_reg.lock_protect_enable && dll_on && lock_lost_i |=> lock_flag_reg && relock_reg)
    else $error("lock loss did not set flag and relock");

  AST_FLAG_STICKY: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    lock_flag_reg && clkdt_reg.lock_protect_enable && !wr_phase |=> lock_flag_reg)
    else $error("lock flag dropped without a software clear");

  AST_CKSEL_FORCED: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    clkdt_reg.delay_loop_enable |-> clkdt_reg.counter_clock_select == 2'b00)
    else $error("clock select not forced while loop on");

  AST_INACTIVE: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    !act |=> high_reg == $past(outctl_reg.high_output_invert) && low_reg == $past(outctl_reg.low_output_invert))
    else $error("outputs not inactive under forced inactive");

  AST_NO_OVERLAP: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
    !(leg_out[0] && leg_out[1]))
    else $error("both legs active together");

  AST_PHASE_XFER: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    wr_duty |=> phase_reg == $past(phase_buf_reg) && duty_reg == $past(wb_dat_i[7:0]))
    else $error("duty write did not move phase buffer");

  AST_PHASE_COPY: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    rd_duty |=> phase_buf_reg == $past(phase_reg))
    else $error("duty read did not copy phase into buffer");

  AST_TAPS: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    1'b1 |=> taps_reg == {$past(clkdt_reg.dead_time_code), 1'b1})
    else $error("dead taps not derived from code");

endmodule // hcpwm_top

/* File: testbench/hcpwm_switch_model.sv */
`timescale 1ns/100ps
// ****************************************
// Converter switch pair seen from the pins
// ****************************************
module hcpwm_switch_model (
  input wire logic clk_i,     // Step clock
  input wire logic rst_i,     // Sync reset, high
  input wire logic high_i,    // High-side drive
  input wire logic low_i,     // Low-side drive
  input wire logic inv_h_i,   // High drive inverted
  input wire logic inv_l_i,   // Low drive inverted
  input wire logic ocp_cmd_i, // Bench asks for OCP
  input wire logic ovp_cmd_i, // Bench asks for OVP
  output logic ocp_trip_o,    // Over-current level
  output logic ovp_trip_o,    // Over-voltage level
  output int overlap_o        // Shoot-through cycles
);
  // Comparator levels follow the bench one cycle late, as a real sense path would;
  // both switches conducting at once would short the supply
  always @(posedge clk_i) begin
    if (rst_i) begin
      ocp_trip_o <= 1'b0;
      ovp_trip_o <= 1'b0;
      overlap_o <= 0;
    end else begin
      ocp_trip_o <= ocp_cmd_i;
      ovp_trip_o <= ovp_cmd_i;
      if (((high_i ^ inv_h_i) === 1'b1) && ((low_i ^ inv_l_i) === 1'b1)) begin
        overlap_o <= overlap_o + 1;
      end
    end
  end
endmodule // hcpwm_switch_model

/* File: testbench/hires_complementary_pwm_tb.sv */
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("BAD %s expected %0h seen %0h", nm, exp, got); end end
// ****************************************
// Self-checking bench for the PWM block
// ****************************************
module hires_complementary_pwm_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic lock_lost_i = 1'b0, ocp_cmd = 1'b0, ovp_cmd = 1'b0, inv_h = 1'b1, inv_l = 1'b0;
  logic wb_ack_o, high_o, low_o, dll_enable_o, dll_relock_o, ocp_trip, ovp_trip;
  logic [31:0] wb_dat_o;
  logic [3:0] tap_h, tap_l;
  logic [15:0] seed = 16'h61e2;
  logic [7:0] v, r;
  int err_total = 0, num_checks = 0, relock_seen = 0, ovl, hi, per, p, d, n0, cnt;
  logic [7:0] rst_tab [5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h20};

  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (dll_relock_o === 1'b1) relock_seen++;

  hcpwm_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .lock_lost_i(lock_lost_i),
    .ocp_trip_i(ocp_trip), .ovp_trip_i(ovp_trip), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .high_side_output_o(high_o), .low_side_output_o(low_o), .dll_enable_o(dll_enable_o),
    .dll_relock_o(dll_relock_o), .high_dead_tap_select_o(tap_h), .low_dead_tap_select_o(tap_l));
  hcpwm_switch_model i_conv (.clk_i(clk_i), .rst_i(rst_i), .high_i(high_o), .low_i(low_o), .inv_h_i(inv_h),
    .inv_l_i(inv_l), .ocp_cmd_i(ocp_cmd), .ovp_cmd_i(ovp_cmd), .ocp_trip_o(ocp_trip), .ovp_trip_o(ovp_trip),
    .overlap_o(ovl));

  // Fixed-seed LFSR so every run sees the same stimulus
  function automatic int rnd(input int lo, input int hi_v);
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return lo + int'(seed) % (hi_v - lo + 1);
  endfunction

  task summarize;
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Classic single Wishbone cycle; waits for ack under a bound
  task wb(input logic we, input logic [2:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {3'h0, idx, 2'h0};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, wd};
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin err_total++; summarize(); end
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task wr(input logic [2:0] idx, input logic [7:0] wd);
    logic [7:0] x;
    wb(1'b1, idx, wd, x);
  endtask
  task rd(input logic [2:0] idx, output logic [7:0] x);
    wb(1'b0, idx, 8'h00, x);
  endtask

  function automatic logic lvl(input logic which);
    return which ? low_o : high_o;
  endfunction
  // High time and rise-to-rise period of one output, in clocks
  task pulse(input logic which, output int h, output int pr);
    int n;
    h = 0; pr = 0; n = 0;
    do begin @(posedge clk_i); n++; end while (lvl(which) !== 1'b0 && n < 5000);
    do begin @(posedge clk_i); n++; end while (lvl(which) !== 1'b1 && n < 5000);
    do begin h++; pr++; @(posedge clk_i); n++; end while (lvl(which) === 1'b1 && n < 5000);
    do begin pr++; @(posedge clk_i); n++; end while (lvl(which) === 1'b0 && n < 5000);
    if (n >= 5000) begin err_total++; summarize(); end
  endtask

  initial begin
    #(25 * 100000);
    err_total++;
    summarize();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // ****************************************
    // Register reset values, unmapped, access
    // ****************************************
    for (int i = 0; i < 5; i++) begin rd(i[2:0], r); `CHK("reset value", rst_tab[i], r) end
    rd(3'h5, r); `CHK("unmapped read", 8'h00, r)
    for (int i = 0; i < 6; i++) begin
      v = 8'(rnd(0, 255)); wr(3'h0, v); rd(3'h0, r); `CHK("period rw", v, r)
      v = 8'(rnd(0, 255)) & 8'hbf; wr(3'h3, v); rd(3'h3, r); `CHK("clock sel free", v, r)
      v = 8'(rnd(0, 255)) | 8'h40; wr(3'h3, v); rd(3'h3, r); `CHK("clock sel forced", v & 8'hcf, r)
    end
    // ****************************************
    // Plain PWM, every counter clock divider
    // ****************************************
    wr(3'h4, 8'h80); inv_h <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      p = rnd(2, 5); d = rnd(1, p - 1);
      wr(3'h0, 8'(p)); wr(3'h1, 8'(d)); wr(3'h3, 8'h08 | 8'(s << 4));
      pulse(1'b0, hi, per);
      `CHK("high width", d * (16 << s), hi)
      `CHK("period", (p + 1) * (16 << s), per)
      pulse(1'b1, hi, per); `CHK("low width no dead", (p + 1 - d) * (16 << s), hi)
    end
    wr(3'h3, 8'h08); `CHK("loop off", 1'b0, dll_enable_o)
    wr(3'h4, 8'hc0); pulse(1'b1, hi, per); `CHK("boost low width", d * 16, hi)
    wr(3'h4, 8'he0); inv_h <= 1'b1; pulse(1'b0, hi, per); `CHK("inverted high", d * 16, hi)
    wr(3'h4, 8'h30); inv_l <= 1'b1; repeat (4) @(posedge clk_i);
    cnt = 0;
    repeat (100) begin @(posedge clk_i); cnt += int'(high_o === 1'b1 && low_o === 1'b1); end
    `CHK("forced inactive", 100, cnt)
    // ****************************************
    // Counter held at zero while disabled
    // ****************************************
    wr(3'h4, 8'h80); inv_h <= 1'b0; inv_l <= 1'b0; wr(3'h3, 8'h00); wr(3'h1, 8'h01); repeat (4) @(posedge clk_i);
    cnt = 0;
    repeat (200) begin @(posedge clk_i); cnt += int'(high_o === 1'b0 && low_o === 1'b1); end
    `CHK("counter frozen", 200, cnt)
    // ****************************************
    // Phase buffer handshake with duty
    // ****************************************
    wr(3'h2, 8'ha0); rd(3'h2, r); `CHK("phase buffered", 8'ha0, r)
    rd(3'h1, r); `CHK("duty read", 8'h01, r)
    rd(3'h2, r); `CHK("phase copied", 8'h00, r)
    wr(3'h2, 8'h70); wr(3'h1, 8'h01); rd(3'h1, r); rd(3'h2, r); `CHK("phase moved", 8'h70, r)
    // ****************************************
    // Delay loop on: phase, dead time, taps
    // ****************************************
    wr(3'h0, 8'h03); wr(3'h3, 8'hf9); rd(3'h3, r); `CHK("sel ignored", 8'hc9, r)
    `CHK("loop on", 1'b1, dll_enable_o)
    n0 = ovl;
    pulse(1'b0, hi, per); `CHK("high fine", 16 + 7 - 3, hi)
    `CHK("loop period", 64, per)
    pulse(1'b1, hi, per); `CHK("low dead", 48 - 7 - 3, hi)
    `CHK("no overlap", n0, ovl)
    `CHK("high tap", 4'h3, tap_h)
    `CHK("low tap", 4'h3, tap_l)
    // ****************************************
    // Lock loss with and without protection
    // ****************************************
    n0 = relock_seen; lock_lost_i <= 1'b1; @(posedge clk_i); lock_lost_i <= 1'b0; repeat (4) @(posedge clk_i);
    `CHK("relock pulse", n0 + 1, relock_seen)
    rd(3'h2, r); `CHK("flag set", 1'b1, r[0])
    wr(3'h2, 8'h71); rd(3'h2, r); `CHK("flag kept", 1'b1, r[0])
    wr(3'h2, 8'h70); rd(3'h2, r); `CHK("flag cleared", 1'b0, r[0])
    wr(3'h3, 8'h49); n0 = relock_seen;
    lock_lost_i <= 1'b1; @(posedge clk_i); lock_lost_i <= 1'b0; repeat (4) @(posedge clk_i);
    `CHK("no relock", n0, relock_seen)
    rd(3'h2, r); `CHK("flag stays low", 1'b0, r[0])
    // ****************************************
    // Protection enables, one leg at a time
    // ****************************************
    wr(3'h3, 8'h08); wr(3'h1, 8'hff);
    for (int i = 0; i < 4; i++) begin
      v = 8'h80 | ((i % 2 == 0) ? 8'h40 : 8'h00);
      wr(3'h4, v); ocp_cmd <= (i >= 2); ovp_cmd <= (i < 2); repeat (6) @(posedge clk_i);
      `CHK("trip ignored", 1'b1, lvl(i % 2 == 0))
      wr(3'h4, v | 8'(1 << i)); repeat (6) @(posedge clk_i);
      `CHK("trip forces", 1'b0, lvl(i % 2 == 0))
      ocp_cmd <= 1'b0; ovp_cmd <= 1'b0; repeat (6) @(posedge clk_i);
      `CHK("trip released", 1'b1, lvl(i % 2 == 0))
    end
    summarize();
  end
endmodule // hires_complementary_pwm_tb
